/* common/bsf_pkg.sv */
package bsf_pkg;

  localparam int          DATA_W      = 32;
  localparam int          APB_ADDR_W  = 8;

  localparam logic [7:0]  ADDR_INSTR   = 8'h00;
  localparam logic [7:0]  ADDR_OPERAND = 8'h04;
  localparam logic [7:0]  ADDR_AMOUNT  = 8'h08;
  localparam logic [7:0]  ADDR_FIRST   = 8'h0c;
  localparam logic [7:0]  ADDR_CTRL    = 8'h10;
  localparam logic [7:0]  ADDR_STATUS  = 8'h14;
  localparam logic [7:0]  ADDR_RESULT  = 8'h18;
  localparam logic [7:0]  ADDR_PC      = 8'h1c;
  localparam logic [7:0]  ADDR_INFO    = 8'h20;

  localparam int          BIT_N        = 31;
  localparam int          BIT_Z        = 30;
  localparam int          BIT_C        = 29;
  localparam int          BIT_V        = 28;
  localparam int          BIT_I        = 27;
  localparam int          BIT_F        = 26;
  localparam int          BIT_M1       = 1;
  localparam int          BIT_M0       = 0;
  localparam logic [31:0] STATUS_MASK  = 32'hfc000003;
  localparam logic [31:0] STATUS_RESET = 32'h0c000003;
  localparam logic [1:0]  USER_MODE    = 2'h0;

  localparam int          PC_LO        = 2;
  localparam int          PC_W         = 24;

  localparam int          INS_IMM      = 25;
  localparam int          INS_OPC_LO   = 21;
  localparam int          INS_SET      = 20;
  localparam int          INS_RD_LO    = 12;
  localparam int          INS_BIT7     = 7;
  localparam int          INS_REGCTL   = 4;
  localparam int          SHIFT_AMT_LO = 7;
  localparam int          SHIFT_TYPE_LO = 5;
  localparam int          IMM_ROT_LO   = 8;
  localparam logic [3:0]  PC_REG_NUM   = 4'hf;

  localparam int          CTRL_GO      = 0;
  localparam int          INFO_CARRY   = 0;
  localparam int          INFO_UNDEF   = 1;
  localparam int          INFO_PC_WR   = 2;
  localparam int          INFO_MODE_CH = 3;

  localparam logic [3:0]  OPC_AND              = 4'h0;
  localparam logic [3:0]  OPC_XOR              = 4'h1;
  localparam logic [3:0]  OPC_SUB              = 4'h2;
  localparam logic [3:0]  OPC_REV_SUB          = 4'h3;
  localparam logic [3:0]  OPC_ADD              = 4'h4;
  localparam logic [3:0]  OPC_ADD_CARRY        = 4'h5;
  localparam logic [3:0]  OPC_SUB_CARRY        = 4'h6;
  localparam logic [3:0]  OPC_REV_SUB_CARRY    = 4'h7;
  localparam logic [3:0]  OPC_TEST_BITS        = 4'h8;
  localparam logic [3:0]  OPC_TEST_EQUAL       = 4'h9;
  localparam logic [3:0]  OPC_COMPARE          = 4'ha;
  localparam logic [3:0]  OPC_COMPARE_NEGATIVE = 4'hb;
  localparam logic [3:0]  OPC_OR               = 4'hc;
  localparam logic [3:0]  OPC_MOVE             = 4'hd;
  localparam logic [3:0]  OPC_BIT_CLEAR        = 4'he;
  localparam logic [3:0]  OPC_MOVE_NOT         = 4'hf;

  typedef enum logic [1:0] {
    logical_left_shift,
    logical_right_shift,
    arithmetic_right_shift,
    rotate_right
  } bsf_shift_type;

endpackage : bsf_pkg

/* rtl/bsf_shifter.sv */
`timescale 1ns/1ps
module bsf_shifter
  import bsf_pkg::*;
(
  input  logic [11:0] operand_field,
  input  logic        use_immediate,
  input  logic        register_shift,
  input  logic [31:0] shifted_operand_register,
  input  logic [31:0] shift_amount_register,
  input  logic        carry_in,
  output logic [31:0] shift_result,
  output logic        shift_carry
);

  bsf_shift_type kind;
  logic [7:0]    amount;
  logic [4:0]    n;
  logic [31:0]   op;
  logic [31:0]   nz_result;
  logic          nz_carry;
  logic [63:0]   doubled;
  logic [4:0]    imm_rot;
  logic [63:0]   imm_doubled;

  assign op          = shifted_operand_register;
  assign kind        = bsf_shift_type'(operand_field[SHIFT_TYPE_LO +: 2]);
  assign amount      = register_shift ? shift_amount_register[7:0]
                                      : {3'h0, operand_field[SHIFT_AMT_LO +: 5]};
  assign n           = amount[4:0];
  assign doubled     = {op, op} >> n;
  assign imm_rot     = {operand_field[IMM_ROT_LO +: 4], 1'b0};
  assign imm_doubled = {24'h000000, operand_field[7:0], 24'h000000, operand_field[7:0]} >> imm_rot;

  // Amounts 1 to 31, shared by both amount sources
  always_comb begin
    nz_carry = op[n - 5'd1];
    case (kind)
      logical_left_shift: begin
        nz_result = op << n;
        nz_carry  = op[5'd0 - n];
      end
      logical_right_shift:    nz_result = op >> n;
      arithmetic_right_shift: nz_result = $unsigned($signed(op) >>> n);
      rotate_right:           nz_result = doubled[31:0];
      default:                nz_result = op;
    endcase
  end

  always_comb begin
    shift_result = nz_result;
    shift_carry  = nz_carry;
    if (use_immediate) begin
      shift_result = imm_doubled[31:0];
      shift_carry  = (imm_rot == 5'h00) ? carry_in : imm_doubled[31];
    end else if (register_shift && amount == 8'h00) begin
      shift_result = op;
      shift_carry  = carry_in;
    end else if (!register_shift && n == 5'h00) begin
      case (kind)
        logical_left_shift: begin
          shift_result = op;
          shift_carry  = carry_in;
        end
        logical_right_shift: begin
          shift_result = 32'h00000000;
          shift_carry  = op[31];
        end
        arithmetic_right_shift: begin
          shift_result = {32{op[31]}};
          shift_carry  = op[31];
        end
        default: begin
          shift_result = {carry_in, op[31:1]};
          shift_carry  = op[0];
        end
      endcase
    end else if (register_shift && amount >= 8'h20) begin
      case (kind)
        logical_left_shift: begin
          shift_result = 32'h00000000;
          shift_carry  = (amount == 8'h20) ? op[0] : 1'b0;
        end
        logical_right_shift: begin
          shift_result = 32'h00000000;
          shift_carry  = (amount == 8'h20) ? op[31] : 1'b0;
        end
        arithmetic_right_shift: begin
          shift_result = {32{op[31]}};
          shift_carry  = op[31];
        end
        default: begin
          // Multiples of 32 act as 32; others reduce to the low five bits
          if (n == 5'h00) begin
            shift_result = op;
            shift_carry  = op[31];
          end
        end
      endcase
    end
  end

endmodule : bsf_shifter

/* rtl/bsf_alu.sv */
`timescale 1ns/1ps
module bsf_alu
  import bsf_pkg::*;
(
  input  logic [3:0]  opcode,
  input  logic [31:0] first,
  input  logic [31:0] second,
  input  logic        carry_in,
  output logic [31:0] result,
  output logic        carry_out,
  output logic        overflow
);

  logic [31:0] x;
  logic [31:0] y;
  logic        ci;
  logic [32:0] sum;
  logic [31:0] logic_r;
  logic        arith;

  always_comb begin
    x       = first;
    y       = second;
    ci      = 1'b0;
    arith   = 1'b1;
    logic_r = 32'h00000000;
    case (opcode)
      OPC_SUB, OPC_COMPARE: begin
        y  = ~second;
        ci = 1'b1;
      end
      OPC_REV_SUB: begin
        x  = second;
        y  = ~first;
        ci = 1'b1;
      end
      OPC_ADD, OPC_COMPARE_NEGATIVE: ci = 1'b0;
      OPC_ADD_CARRY: ci = carry_in;
      OPC_SUB_CARRY: begin
        y  = ~second;
        ci = carry_in;
      end
      OPC_REV_SUB_CARRY: begin
        x  = second;
        y  = ~first;
        ci = carry_in;
      end
      default: begin
        arith = 1'b0;
        case (opcode)
          OPC_AND, OPC_TEST_BITS:   logic_r = first & second;
          OPC_XOR, OPC_TEST_EQUAL:  logic_r = first ^ second;
          OPC_OR:                   logic_r = first | second;
          OPC_MOVE:                 logic_r = second;
          OPC_BIT_CLEAR:            logic_r = first & ~second;
          default:                  logic_r = ~second;
        endcase
      end
    endcase
  end

  assign sum       = {1'b0, x} + {1'b0, y} + {32'h00000000, ci};
  assign result    = arith ? sum[31:0] : logic_r;
  assign carry_out = sum[32];
  // Signed overflow: like-signed inputs give an unlike-signed sum
  assign overflow  = (x[31] == y[31]) && (sum[31] != x[31]);

endmodule : bsf_alu

/* rtl/bsf_barrel_flags.sv */
`timescale 1ns/1ps
// How it works
// - Logical set-flags: keep V, set Z, N
// - Logical carry from shifter; left zero keeps it
// - Arithmetic set-flags: V, C, Z, N from ALU
// - Shift type from field, amount immediate or register
// - Left shift zero-fills, last bit out is carry
// - Immediate left zero passes operand, old carry
// - Immediate right zero means 32: zero, bit 31
// - Arithmetic right fills sign; zero means 32
// - Rotate right reinserts low bits at top
// - Immediate rotate zero is 33-bit extended rotate
// - Register amount uses low byte; zero passes
// - Register amounts 1-31 match immediate shifts
// - Logical shifts by 32 and beyond zero result
// - Arithmetic right 32 or more gives sign
// - Rotate by 32 passes, larger reduces mod 32
// - Bit 7 set with register shift: not executed
// - Immediate: zero-extend byte, rotate by twice field
// - Program counter destination with set: load N Z C V
// - Privileged modes also load I F mode bits
// - Program counter destination without set: status untouched
// - Compare and test to program counter update status
module bsf_barrel_flags
  import bsf_pkg::*;
(
  input  logic                  pclk,
  input  logic                  presetn,
  input  logic                  psel,
  input  logic                  penable,
  input  logic                  pwrite,
  input  logic [APB_ADDR_W-1:0] paddr,
  input  logic [31:0]           pwdata,
  input  logic [3:0]            pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           status_word
);

  logic [31:0]   instr_word;
  logic [31:0]   shifted_operand_register;
  logic [31:0]   shift_amount_register;
  logic [31:0]   first_operand;
  logic [31:0]   result_word;
  logic [PC_W-1:0] program_counter_bits;
  logic [3:0]    info_bits;
  logic [31:0]   pc_merged;

  logic          apb_setup;
  logic          apb_access;
  logic          wr_en;
  logic          rd_hit;
  logic [31:0]   rd_value;

  logic          use_immediate;
  logic          register_shift;
  logic          undefined;
  logic [3:0]    opcode;
  logic          set_flags;
  logic          dest_pc;
  logic          is_test;
  logic          logical;
  logic          user_mode;
  logic          exec;
  logic          run;

  logic [31:0]   sh_res;
  logic          sh_c;
  logic [31:0]   alu_res;
  logic          alu_c;
  logic          alu_v;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge_bytes

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable && pready;
  assign wr_en      = apb_access && pwrite;
  assign pc_merged  = merge_bytes({6'h00, program_counter_bits, 2'h0}, pwdata, pstrb);

  assign use_immediate  = instr_word[INS_IMM];
  assign register_shift = !use_immediate && instr_word[INS_REGCTL];
  assign undefined      = register_shift && instr_word[INS_BIT7];
  assign opcode         = instr_word[INS_OPC_LO +: 4];
  assign set_flags      = instr_word[INS_SET];
  assign dest_pc        = instr_word[INS_RD_LO +: 4] == PC_REG_NUM;
  assign is_test        = opcode[3:2] == 2'h2;
  assign logical        = !opcode[3] ? (opcode[3:1] == 3'h0) : (opcode[3:1] != 3'h5);
  assign user_mode      = status_word[BIT_M1:BIT_M0] == USER_MODE;

  // Writing the go bit runs the loaded instruction once
  assign exec = wr_en && paddr == ADDR_CTRL && pstrb[0] && pwdata[CTRL_GO];
  assign run  = exec && !undefined;

  bsf_shifter u_shifter (
    .operand_field            (instr_word[11:0]),
    .use_immediate            (use_immediate),
    .register_shift           (register_shift),
    .shifted_operand_register (shifted_operand_register),
    .shift_amount_register    (shift_amount_register),
    .carry_in                 (status_word[BIT_C]),
    .shift_result             (sh_res),
    .shift_carry              (sh_c)
  );

  bsf_alu u_alu (
    .opcode    (opcode),
    .first     (first_operand),
    .second    (sh_res),
    .carry_in  (status_word[BIT_C]),
    .result    (alu_res),
    .carry_out (alu_c),
    .overflow  (alu_v)
  );

  // Zero-wait slave: answer is prepared in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_value;
      pslverr <= !rd_hit;
    end
  end

  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h00000000;
    case (paddr)
      ADDR_INSTR:   rd_value = instr_word;
      ADDR_OPERAND: rd_value = shifted_operand_register;
      ADDR_AMOUNT:  rd_value = shift_amount_register;
      ADDR_FIRST:   rd_value = first_operand;
      ADDR_CTRL:    rd_value = 32'h00000000;
      ADDR_STATUS:  rd_value = status_word;
      ADDR_RESULT:  rd_value = result_word;
      ADDR_PC:      rd_value = {6'h00, program_counter_bits, 2'h0};
      ADDR_INFO:    rd_value = {28'h0000000, info_bits};
      default:      rd_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_word               <= 32'h00000000;
      shifted_operand_register <= 32'h00000000;
      shift_amount_register    <= 32'h00000000;
      first_operand            <= 32'h00000000;
    end else if (wr_en) begin
      case (paddr)
        ADDR_INSTR:   instr_word               <= merge_bytes(instr_word, pwdata, pstrb);
        ADDR_OPERAND: shifted_operand_register <= merge_bytes(shifted_operand_register, pwdata, pstrb);
        ADDR_AMOUNT:  shift_amount_register    <= merge_bytes(shift_amount_register, pwdata, pstrb);
        ADDR_FIRST:   first_operand            <= merge_bytes(first_operand, pwdata, pstrb);
        default:      instr_word               <= instr_word;
      endcase
    end
  end

  // Status flags; go and status writes never share an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= STATUS_RESET;
    end else if (wr_en && paddr == ADDR_STATUS) begin
      status_word <= merge_bytes(status_word, pwdata, pstrb) & STATUS_MASK;
    end else if (run && set_flags) begin
      if (dest_pc) begin
        status_word[BIT_N:BIT_V] <= alu_res[BIT_N:BIT_V];
        if (!user_mode) begin
          status_word[BIT_I]         <= alu_res[BIT_I];
          status_word[BIT_F]         <= alu_res[BIT_F];
          status_word[BIT_M1:BIT_M0] <= alu_res[BIT_M1:BIT_M0];
        end
      end else if (logical) begin
        status_word[BIT_N] <= alu_res[31];
        status_word[BIT_Z] <= alu_res == 32'h00000000;
        status_word[BIT_C] <= sh_c;
      end else begin
        status_word[BIT_N] <= alu_res[31];
        status_word[BIT_Z] <= alu_res == 32'h00000000;
        status_word[BIT_C] <= alu_c;
        status_word[BIT_V] <= alu_v;
      end
    end
  end

  // Without set-flags a program counter write leaves status alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter_bits <= '0;
    end else if (wr_en && paddr == ADDR_PC) begin
      program_counter_bits <= pc_merged[PC_LO +: PC_W];
    end else if (run && dest_pc && !is_test) begin
      program_counter_bits <= alu_res[PC_LO +: PC_W];
    end
  end

  // Compare and test results are not kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_word <= 32'h00000000;
    end else if (run && !is_test) begin
      result_word <= alu_res;
    end
  end

  // Mode change flag lets the issuer pad the next banked access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_bits <= 4'h0;
    end else if (exec) begin
      info_bits[INFO_CARRY]   <= sh_c;
      info_bits[INFO_UNDEF]   <= undefined;
      info_bits[INFO_PC_WR]   <= run && dest_pc && !is_test;
      info_bits[INFO_MODE_CH] <= run && dest_pc && set_flags && !user_mode
                                 && alu_res[BIT_M1:BIT_M0] != status_word[BIT_M1:BIT_M0];
    end
  end

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready && pslverr == !$past(rd_hit)
      && prdata == ($past(pwrite) ? 32'h00000000 : $past(rd_value)))
    else $error("apb answer not ready after setup");

  chk_logic_flags: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && !dest_pc && logical |=>
      status_word[BIT_N] == $past(alu_res[31]) && status_word[BIT_Z] == ($past(alu_res) == 32'h00000000)
      && status_word[BIT_V] == $past(status_word[BIT_V]))
    else $error("logical flags wrong");

  chk_logic_carry: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && !dest_pc && logical |=> status_word[BIT_C] == $past(sh_c))
    else $error("logical carry not from shifter");

  chk_arith_flags: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && !dest_pc && !logical |=>
      status_word[BIT_C] == $past(alu_c) && status_word[BIT_V] == $past(alu_v)
      && status_word[BIT_N] == $past(alu_res[31]))
    else $error("arithmetic flags wrong");

  chk_pc_flags: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && dest_pc |=> status_word[BIT_N:BIT_V] == $past(alu_res[BIT_N:BIT_V]))
    else $error("status flags not loaded from result");

  chk_user_protect: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && dest_pc && user_mode |=> $stable(status_word[BIT_I:BIT_F])
      && $stable(status_word[BIT_M1:BIT_M0]))
    else $error("protected bits changed in user mode");

  chk_priv_load: assert property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && dest_pc && !user_mode |=> status_word[BIT_I:BIT_F] == $past(alu_res[BIT_I:BIT_F])
      && status_word[BIT_M1:BIT_M0] == $past(alu_res[BIT_M1:BIT_M0]))
    else $error("control bits not loaded in privileged mode");

  chk_pc_no_set: assert property (@(posedge pclk) disable iff (!presetn)
    run && !set_flags && dest_pc && !is_test |=> $stable(status_word)
      && program_counter_bits == $past(alu_res[PC_LO +: PC_W]))
    else $error("program counter write without set changed status");

  chk_test_to_pc: assert property (@(posedge pclk) disable iff (!presetn)
    run && is_test && dest_pc |=> $stable(program_counter_bits) && $stable(result_word))
    else $error("test operation wrote a result");

  chk_undef_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    exec && undefined |=> $stable(status_word) && $stable(result_word) && info_bits[INFO_UNDEF])
    else $error("undefined instruction had effect");

  chk_lsr_by_32: assert property (@(posedge pclk) disable iff (!presetn)
    !use_immediate && !register_shift && instr_word[6:5] == 2'h1 && instr_word[11:7] == 5'h00
      |-> sh_res == 32'h00000000 && sh_c == shifted_operand_register[31])
    else $error("right shift by 32 wrong");

  chk_ext_rotate: assert property (@(posedge pclk) disable iff (!presetn)
    !use_immediate && !register_shift && instr_word[6:5] == 2'h3 && instr_word[11:7] == 5'h00
      |-> sh_res == {status_word[BIT_C], shifted_operand_register[31:1]}
      && sh_c == shifted_operand_register[0])
    else $error("extended rotate wrong");

  chk_reg_zero: assert property (@(posedge pclk) disable iff (!presetn)
    register_shift && shift_amount_register[7:0] == 8'h00
      |-> sh_res == shifted_operand_register && sh_c == status_word[BIT_C])
    else $error("zero register shift not a pass");

  cov_logic_exec: cover property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && logical && !dest_pc);
  cov_arith_exec: cover property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && !logical && !dest_pc);
  cov_priv_pc: cover property (@(posedge pclk) disable iff (!presetn)
    run && set_flags && dest_pc && !user_mode);
  cov_undefined: cover property (@(posedge pclk) disable iff (!presetn)
    exec && undefined);

endmodule : bsf_barrel_flags

/* dv/bsf_apb_host.sv */
`timescale 1ns/1ps
module bsf_apb_host
  import bsf_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // Request held until pready is seen high at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
endmodule : bsf_apb_host

/* dv/barrel_shifter_alu_flags_test.sv */
`timescale 1ns/1ps
module barrel_shifter_alu_flags_test
  import bsf_pkg::*;
;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, status_word, q;
  logic [3:0]  pstrb;
  logic        e;
  int          err_count = 0;
  int          n_checks = 0;
  localparam logic [31:0] A  = 32'h80000003;
  localparam logic [31:0] S0 = 32'h0c000003;
  localparam logic [31:0] SC = 32'h2c000003;
  localparam bsf_shift_type LL = logical_left_shift;
  localparam bsf_shift_type LR = logical_right_shift;
  localparam bsf_shift_type AR = arithmetic_right_shift;
  localparam bsf_shift_type RR = rotate_right;
  always #25 pclk = ~pclk;
  bsf_barrel_flags i_bsf_barrel_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_word(status_word));
  bsf_apb_host i_bsf_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      err_count++;
    end
    n_checks++;
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_bsf_apb_host.xfer(1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a);
    i_bsf_apb_host.xfer(0, a, 32'h0, q, e);
  endtask : rd
  function automatic logic [31:0] mk(logic i, logic [3:0] o, logic s, logic [3:0] d, logic [11:0] p);
    return {4'he, 2'b00, i, o, s, 4'h0, d, p};
  endfunction : mk
  function automatic logic [31:0] sh(logic [4:0] n, bsf_shift_type t);
    return mk(0, OPC_MOVE, 1, 4'h0, {n, t, 1'b0, 4'h0});
  endfunction : sh
  function automatic logic [31:0] rs(bsf_shift_type t);
    return mk(0, OPC_MOVE, 1, 4'h0, {4'h1, 1'b0, t, 1'b1, 4'h0});
  endfunction : rs
  task go(input logic [31:0] ins, input logic [31:0] st, input logic [31:0] xs);
    wr(ADDR_STATUS, st);
    wr(ADDR_INSTR, ins);
    wr(ADDR_CTRL, 32'h1);
    @(posedge pclk);
    chk("status_word", xs, status_word);
  endtask : go
  task run(input logic [31:0] ins, op, amt, f, st, res, xs);
    wr(ADDR_OPERAND, op);
    wr(ADDR_AMOUNT, amt);
    wr(ADDR_FIRST, f);
    go(ins, st, xs);
    rd(ADDR_RESULT);
    chk("result", res, q);
  endtask : run
  task give_verdict;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Generous bound: a few hundred bus cycles are expected
  initial begin
    repeat (8000) @(posedge pclk);
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    chk("reset status", S0, status_word);
    run(sh(1, LL), A, 0, 0, S0, 32'h6, SC);
    run(sh(0, LL), A, 0, 0, SC, A, 32'hac000003);
    run(sh(0, LR), A, 0, 0, 32'h1c000003, 0, 32'h7c000003);
    run(sh(0, AR), A, 0, 0, S0, 32'hffffffff, 32'hac000003);
    run(sh(4, RR), A, 0, 0, SC, 32'h38000000, S0);
    run(sh(0, RR), A, 0, 0, SC, 32'hc0000001, 32'hac000003);
    run(rs(LL), A, 32'h100, 0, S0, A, 32'h8c000003);
    run(rs(LL), A, 32, 0, S0, 0, 32'h6c000003);
    run(rs(LL), A, 33, 0, SC, 0, 32'h4c000003);
    run(rs(LR), A, 32, 0, S0, 0, 32'h6c000003);
    run(rs(AR), A, 40, 0, S0, 32'hffffffff, 32'hac000003);
    run(rs(RR), A, 32, 0, S0, A, 32'hac000003);
    run(rs(RR), A, 36, 0, SC, 32'h38000000, S0);
    run(rs(LR), A, 1, 0, S0, 32'h40000001, SC);
    run(mk(1, OPC_MOVE, 1, 0, 12'h103), 0, 0, 0, S0, 32'hc0000000, 32'hac000003);
    run(mk(1, OPC_ADD_CARRY, 1, 0, 12'h001), 0, 0, 32'hffffffff, SC, 1, SC);
    run(mk(1, OPC_REV_SUB, 1, 0, 12'h001), 0, 0, 2, S0, 32'hffffffff, 32'h8c000003);
    run(mk(1, OPC_SUB_CARRY, 1, 0, 12'h001), 0, 0, 32'h80000000, S0, 32'h7ffffffe, 32'h3c000003);
    run(mk(1, OPC_REV_SUB_CARRY, 1, 0, 12'h001), 0, 0, 0, SC, 1, SC);
    run(mk(1, OPC_BIT_CLEAR, 1, 0, 12'h0ff), 0, 0, 32'hffffffff, SC, 32'hffffff00, 32'hac000003);
    run(mk(1, OPC_MOVE_NOT, 1, 0, 12'h000), 0, 0, 0, S0, 32'hffffffff, 32'h8c000003);
    run(mk(1, OPC_XOR, 1, 0, 12'h0ff), 0, 0, 32'hff, S0, 0, 32'h4c000003);
    run(mk(1, OPC_OR, 1, 0, 12'h0ff), 0, 0, 32'h100, S0, 32'h1ff, S0);
    run(mk(1, OPC_TEST_EQUAL, 1, 0, 12'h001), 0, 0, 1, S0, 32'h1ff, 32'h4c000003);
    run(mk(1, OPC_COMPARE_NEGATIVE, 1, 0, 12'h001), 0, 0, 32'hffffffff, S0, 32'h1ff, 32'h6c000003);
    run(mk(1, OPC_ADD, 1, 0, 12'h001), 0, 0, 32'h7fffffff, S0, 32'h80000000, 32'h9c000003);
    run(mk(1, OPC_SUB, 1, 0, 12'h001), 0, 0, 1, S0, 0, 32'h6c000003);
    run(rs(LL) | 32'h80, A, 1, 1, S0, 0, S0);
    go(mk(1, OPC_MOVE, 1, 4'hf, 12'h40f), S0, 32'h0c000000);
    rd(ADDR_INFO);
    chk("info", 32'hc, q);
    rd(ADDR_PC);
    chk("pc", 32'h03000000, q);
    // Mode just changed, so only unbanked state is touched next
    go(mk(1, OPC_MOVE, 1, 4'hf, 12'h4ff), 32'h0c000000, 32'hfc000000);
    go(mk(1, OPC_MOVE, 0, 4'hf, 12'h4ff), S0, S0);
    go(mk(1, OPC_COMPARE, 1, 4'hf, 12'h001), S0, 32'h0);
    rd(8'h24);
    chk("slverr", 1, e);
    give_verdict;
  end
endmodule : barrel_shifter_alu_flags_test
